// ===== hw/fbsr_defines.svh
// Constants for the flash bank status register block
`ifndef FBSR_DEFINES_SVH
`define FBSR_DEFINES_SVH
// ==========================================
// Status bit positions
`define FBSR_BIT_READY        7
`define FBSR_BIT_ERS_SUSP     6
`define FBSR_BIT_ERS_ERR      5
`define FBSR_BIT_PRG_ERR      4
`define FBSR_BIT_SUPPLY_ERR   3
`define FBSR_BIT_PRG_SUSP     2
`define FBSR_BIT_PROT_ERR     1
// ==========================================
// Reset value: ready, no suspend, no errors
`define FBSR_STATUS_RESET     8'h80
// ==========================================
// Suspend latencies
`define FBSR_CLK_PERIOD_NS    4
`define FBSR_ERS_SUSP_NS      30000
`define FBSR_PRG_SUSP_NS      5000
`define FBSR_ERS_SUSP_CYC     (`FBSR_ERS_SUSP_NS / `FBSR_CLK_PERIOD_NS)
`define FBSR_PRG_SUSP_CYC     (`FBSR_PRG_SUSP_NS / `FBSR_CLK_PERIOD_NS)
`endif

// ===== hw/fbsr_pkg.sv
// Types for the flash bank status register block
package fbsr_pkg;
    // ==========================================
    // Per-bank controller state
    typedef enum logic [2:0] {
        FBSR_IDLE,
        FBSR_PROGRAM,
        FBSR_ERASE,
        FBSR_SUSP_WAIT,
        FBSR_SUSPENDED
    } fbsr_state_e;

    typedef struct packed {
        fbsr_state_e state;
        logic        was_erase;
        logic [13:0] susp_cnt;
        logic [7:0]  status;
    } fbsr_bank_s;

    typedef struct packed {
        fbsr_bank_s [1:0] bank;
        logic [2:0]       ce_sync;
        logic [2:0]       oe_sync;
        logic             ce_lvl;
        logic             oe_lvl;
        logic [7:0]       held;
        logic             held_valid;
        logic [15:0]      dout;
        logic             dout_status;
    } fbsr_state_s;
endpackage

// ===== hw/fbsr_status.sv
// Dual-bank program/erase status register with output latching
`timescale 1ns/1ps
`include "fbsr_defines.svh"

module fbsr_status
    import fbsr_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce_b,
    input  wire logic        i_oe_b,
    input  wire logic        i_read_bank,
    input  wire logic        i_read_status,
    input  wire logic [15:0] i_array_data,
    input  wire logic [1:0]  i_cmd_program,
    input  wire logic [1:0]  i_cmd_erase,
    input  wire logic [1:0]  i_cmd_suspend,
    input  wire logic [1:0]  i_cmd_resume,
    input  wire logic [1:0]  i_cmd_clear,
    input  wire logic [1:0]  i_block_locked,
    input  wire logic [1:0]  i_supply_lockout_level,
    input  wire logic [1:0]  i_op_done,
    input  wire logic [1:0]  i_verify_fail,
    input  wire logic [1:0]  i_paused,
    output logic      [15:0] o_data,
    output logic             o_data_is_status,
    output logic      [1:0]  o_op_start,
    output logic      [1:0]  o_op_pause,
    output logic      [1:0]  o_op_resume,
    output logic      [1:0]  o_op_failed
);

    localparam logic [13:0] ERS_SUSP_CYC = 14'(`FBSR_ERS_SUSP_CYC);
    localparam logic [13:0] PRG_SUSP_CYC = 14'(`FBSR_PRG_SUSP_CYC);
    localparam logic [7:0]  ERR_MASK     = 8'h3A;

    fbsr_state_s r;
    fbsr_state_s next_r;
    logic        ce_fall;
    logic        oe_fall;
    logic        released;

    // ==========================================
    // Enable pins: three-stage sync, change counted when stages two and three agree
    always_comb begin
        ce_fall  = (r.ce_sync[2] == r.ce_sync[1]) && r.ce_lvl && !r.ce_sync[2];
        oe_fall  = (r.oe_sync[2] == r.oe_sync[1]) && r.oe_lvl && !r.oe_sync[2];
        released = (r.ce_sync[2] == r.ce_sync[1]) && r.ce_sync[2] ||
                   (r.oe_sync[2] == r.oe_sync[1]) && r.oe_sync[2];
    end

    // ==========================================
    // Next-state logic for both banks and the read path
    always_comb begin
        next_r         = r;
        o_op_start     = 2'h0;
        o_op_pause     = 2'h0;
        o_op_resume    = 2'h0;
        o_op_failed    = 2'h0;
        next_r.ce_sync = {r.ce_sync[1:0], i_ce_b};
        next_r.oe_sync = {r.oe_sync[1:0], i_oe_b};
        if (r.ce_sync[2] == r.ce_sync[1]) begin
            next_r.ce_lvl = r.ce_sync[2];
        end
        if (r.oe_sync[2] == r.oe_sync[1]) begin
            next_r.oe_lvl = r.oe_sync[2];
        end

        // Each bank runs independently; no state is shared between them
        for (int b = 0; b < 2; b++) begin
            case (r.bank[b].state)
                FBSR_IDLE: begin
                    if (i_cmd_clear[b]) begin
                        next_r.bank[b].status = r.bank[b].status & ~ERR_MASK;
                    end else if (i_cmd_program[b] || i_cmd_erase[b]) begin
                        next_r.bank[b].was_erase = i_cmd_erase[b];
                        if ((r.bank[b].status & ERR_MASK) != 8'h00) begin
                            o_op_failed[b] = 1'b1;
                        end else if (i_supply_lockout_level[b]) begin
                            // Supply looked at only here, never mid-operation
                            next_r.bank[b].status[`FBSR_BIT_SUPPLY_ERR] = 1'b1;
                            o_op_failed[b] = 1'b1;
                        end else if (i_block_locked[b]) begin
                            next_r.bank[b].status[`FBSR_BIT_PROT_ERR] = 1'b1;
                            o_op_failed[b] = 1'b1;
                        end else begin
                            o_op_start[b] = 1'b1;
                            next_r.bank[b].state = i_cmd_erase[b] ? FBSR_ERASE : FBSR_PROGRAM;
                            next_r.bank[b].status[`FBSR_BIT_READY] = 1'b0;
                        end
                    end
                end
                FBSR_PROGRAM, FBSR_ERASE: begin
                    if (i_op_done[b]) begin
                        next_r.bank[b].state = FBSR_IDLE;
                        next_r.bank[b].status[`FBSR_BIT_READY] = 1'b1;
                        if (i_verify_fail[b]) begin
                            if (r.bank[b].was_erase) begin
                                next_r.bank[b].status[`FBSR_BIT_ERS_ERR] = 1'b1;
                            end else begin
                                next_r.bank[b].status[`FBSR_BIT_PRG_ERR] = 1'b1;
                            end
                        end
                    end else if (i_cmd_suspend[b]) begin
                        o_op_pause[b] = 1'b1;
                        next_r.bank[b].state = FBSR_SUSP_WAIT;
                        next_r.bank[b].susp_cnt = r.bank[b].was_erase ?
                                                  ERS_SUSP_CYC : PRG_SUSP_CYC;
                    end
                end
                FBSR_SUSP_WAIT: begin
                    // Ready stays low until the array engine reports the pause, the operation finishes or the suspend count runs out
                    if (i_op_done[b]) begin
                        next_r.bank[b].state = FBSR_IDLE;
                        next_r.bank[b].status[`FBSR_BIT_READY] = 1'b1;
                        if (i_verify_fail[b]) begin
                            if (r.bank[b].was_erase) begin
                                next_r.bank[b].status[`FBSR_BIT_ERS_ERR] = 1'b1;
                            end else begin
                                next_r.bank[b].status[`FBSR_BIT_PRG_ERR] = 1'b1;
                            end
                        end
                    end else if (i_paused[b] || r.bank[b].susp_cnt <= 14'h0001) begin
                        // Deadline forces the pause even if the engine is slow
                        next_r.bank[b].state = FBSR_SUSPENDED;
                        next_r.bank[b].status[`FBSR_BIT_READY] = 1'b1;
                        if (r.bank[b].was_erase) begin
                            next_r.bank[b].status[`FBSR_BIT_ERS_SUSP] = 1'b1;
                        end else begin
                            next_r.bank[b].status[`FBSR_BIT_PRG_SUSP] = 1'b1;
                        end
                    end else begin
                        next_r.bank[b].susp_cnt = r.bank[b].susp_cnt - 14'h0001;
                    end
                end
                FBSR_SUSPENDED: begin
                    if (i_cmd_resume[b]) begin
                        o_op_resume[b] = 1'b1;
                        next_r.bank[b].state = r.bank[b].was_erase ? FBSR_ERASE : FBSR_PROGRAM;
                        next_r.bank[b].status[`FBSR_BIT_READY]    = 1'b0;
                        next_r.bank[b].status[`FBSR_BIT_ERS_SUSP] = 1'b0;
                        next_r.bank[b].status[`FBSR_BIT_PRG_SUSP] = 1'b0;
                    end else if (i_cmd_clear[b]) begin
                        next_r.bank[b].status = r.bank[b].status & ~ERR_MASK;
                    end
                end
                default: begin
                    next_r.bank[b] = '{FBSR_IDLE, 1'b0, 14'h0000, `FBSR_STATUS_RESET};
                end
            endcase
            // Reserved bit held at zero; host masks it anyway
            next_r.bank[b].status[0] = 1'b0;
        end

        // Latch the addressed bank on an enable fall, hold until release
        if ((ce_fall || oe_fall) && !r.held_valid) begin
            next_r.held       = r.bank[i_read_bank].status;
            next_r.held_valid = 1'b1;
        end else if (released) begin
            next_r.held_valid = 1'b0;
        end

        // Busy bank hides its array behind its status
        if (i_read_status || r.bank[i_read_bank].state != FBSR_IDLE) begin
            next_r.dout_status = 1'b1;
            next_r.dout = {8'h00, r.held_valid ? r.held : r.bank[i_read_bank].status};
        end else begin
            next_r.dout_status = 1'b0;
            next_r.dout = i_array_data;
        end
    end

    // ==========================================
    // State register; reset clears errors and leaves banks ready
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r.bank[0]    <= '{FBSR_IDLE, 1'b0, 14'h0000, `FBSR_STATUS_RESET};
            r.bank[1]    <= '{FBSR_IDLE, 1'b0, 14'h0000, `FBSR_STATUS_RESET};
            r.ce_sync    <= 3'h7;
            r.oe_sync    <= 3'h7;
            r.ce_lvl     <= 1'b1;
            r.oe_lvl     <= 1'b1;
            r.held       <= 8'h00;
            r.held_valid <= 1'b0;
            r.dout       <= 16'h0000;
            r.dout_status <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign o_data           = r.dout;
    assign o_data_is_status = r.dout_status;

endmodule // fbsr_status

// ===== verif/fbsr_props.sv
// Port-level properties of the flash bank status block
`timescale 1ns/1ps
module fbsr_props (
    input wire logic        i_clk_sys,
    input wire logic        i_rst_b,
    input wire logic [1:0]  i_cmd_program,
    input wire logic [1:0]  i_cmd_erase,
    input wire logic [1:0]  i_cmd_suspend,
    input wire logic [1:0]  i_cmd_resume,
    input wire logic [1:0]  i_block_locked,
    input wire logic [1:0]  i_supply_lockout_level,
    input wire logic [15:0] o_data,
    input wire logic        o_data_is_status,
    input wire logic [1:0]  o_op_start,
    input wire logic [1:0]  o_op_pause,
    input wire logic [1:0]  o_op_resume,
    input wire logic [1:0]  o_op_failed
);
    // ==========================================
    // Properties, one clock domain
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence s_req; |(i_cmd_program | i_cmd_erase); endsequence
    property p_upper_zero; o_data_is_status |-> o_data[15:8] == 8'h00; endproperty
    property p_start_cause; |o_op_start |-> (o_op_start & ~(i_cmd_program | i_cmd_erase)) == 2'b00; endproperty
    property p_fail_excl; s_req |-> (o_op_start & o_op_failed) == 2'b00; endproperty
    property p_locked; s_req |-> (o_op_start & i_block_locked) == 2'b00; endproperty
    property p_supply; s_req |-> (o_op_start & i_supply_lockout_level) == 2'b00; endproperty
    property p_pause_cause; |o_op_pause |-> (o_op_pause & ~i_cmd_suspend) == 2'b00; endproperty
    property p_resume_cause; |o_op_resume |-> (o_op_resume & ~i_cmd_resume) == 2'b00; endproperty
    // A started bank leaves idle, so a second start a cycle later is a slip
    property p_start_once; |o_op_start |=> (o_op_start & $past(o_op_start)) == 2'b00; endproperty
    property p_reset_quiet; $rose(i_rst_b) |-> o_data == 16'h0000 && !o_data_is_status; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");
    a_start_cause: assert property (p_start_cause) else $error("start without cmd");
    a_fail_excl: assert property (p_fail_excl) else $error("start and fail");
    a_locked: assert property (p_locked) else $error("locked block started");
    a_supply: assert property (p_supply) else $error("low supply started");
    a_pause_cause: assert property (p_pause_cause) else $error("pause without cmd");
    a_resume_cause: assert property (p_resume_cause) else $error("resume without cmd");
    a_start_once: assert property (p_start_once) else $error("start twice");
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset output");
endmodule // fbsr_props

bind fbsr_status fbsr_props u_props (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_cmd_program(i_cmd_program), .i_cmd_erase(i_cmd_erase), .i_cmd_suspend(i_cmd_suspend),
    .i_cmd_resume(i_cmd_resume), .i_block_locked(i_block_locked),
    .i_supply_lockout_level(i_supply_lockout_level), .o_data(o_data),
    .o_data_is_status(o_data_is_status), .o_op_start(o_op_start), .o_op_pause(o_op_pause),
    .o_op_resume(o_op_resume), .o_op_failed(o_op_failed));

// ===== verif/fbsr_host.sv
// Host bus model: enable toggling and status reads
`timescale 1ns/1ps
module fbsr_host (
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_data,
    input  wire logic        i_data_is_status,
    output logic             o_ce_b,
    output logic             o_oe_b,
    output logic             o_bank,
    output logic             o_status_mode
);
    // ==========================================
    // Bus cycle tasks; reads wait out the pin synchroniser
    initial {o_ce_b, o_oe_b, o_bank, o_status_mode} = 4'b0100;
    task automatic rd_open(input logic b, input logic m);
        @(negedge i_clk_sys);
        {o_bank, o_status_mode, o_oe_b} = {b, m, 1'b0};
        repeat (8) @(negedge i_clk_sys);
    endtask
    task automatic rd_take(output logic [15:0] d, output logic s);
        d = i_data & 16'hFFFE; // Reserved bit dropped
        s = i_data_is_status;
    endtask
    // Raise enable so the next read sees fresh status
    task automatic rd_close;
        o_oe_b = 1'b1;
        repeat (8) @(negedge i_clk_sys);
    endtask
    task automatic rd(input logic b, input logic m, output logic [15:0] d, output logic s);
        rd_open(b, m);
        rd_take(d, s);
        rd_close();
    endtask
endmodule // fbsr_host

// ===== verif/fbsr_status_tb.sv
// Self-checking bench for the flash bank status block
`timescale 1ns/1ps
module fbsr_status_tb;
    logic        clk = 0, rst_b = 0, st, ce_b, oe_b, bank, smode;
    logic [1:0]  prog = 0, ers = 0, sus = 0, res = 0, clr = 0, lck = 0, sup = 0, done = 0, vf = 0, pau = 0;
    logic [1:0]  o_s, o_f, o_p, o_r;
    logic [15:0] dat, rd;
    logic [3:0]  obs;
    int          err_count = 0, compares = 0, cyc = 0;
    wire         st_w;
    // Rows: kind, lock, supply, verify fail, start, status
    logic [15:0] rows [5] = '{16'h0180, 16'h0390, 16'h13A0, 16'h1882, 16'h0488};
    initial forever #2 clk = ~clk;
    fbsr_status DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce_b(ce_b), .i_oe_b(oe_b),
        .i_read_bank(bank), .i_read_status(smode), .i_array_data(16'h5A3C), .i_cmd_program(prog),
        .i_cmd_erase(ers), .i_cmd_suspend(sus), .i_cmd_resume(res), .i_cmd_clear(clr),
        .i_block_locked(lck), .i_supply_lockout_level(sup), .i_op_done(done), .i_verify_fail(vf),
        .i_paused(pau), .o_data(dat), .o_data_is_status(st_w), .o_op_start(o_s),
        .o_op_pause(o_p), .o_op_resume(o_r), .o_op_failed(o_f));
    fbsr_host HOST (.i_clk_sys(clk), .i_data(dat), .i_data_is_status(st_w), .o_ce_b(ce_b),
        .o_oe_b(oe_b), .o_bank(bank), .o_status_mode(smode));
    // ==========================================
    // Checking and stimulus tasks
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One-cycle command pulse; outputs are combinational, so look 1 ns in
    task automatic pulse(input int k, input int b);
        logic [1:0] m;
        m = 2'b01 << b;
        @(negedge clk);
        case (k) 0: prog = m; 1: ers = m; 2: sus = m; 3: res = m; 4: clr = m; 5: done = m; default: pau = m; endcase
        #1 obs = {o_s[b], o_f[b], o_p[b], o_r[b]};
        @(negedge clk);
        {prog, ers, sus, res, clr, done, pau} = '0;
    endtask
    task automatic rs(input int b, input logic [7:0] e);
        HOST.rd(b[0], 1'b1, rd, st);
        chk("status", rd, {8'h00, e});
    endtask
    // Hang guard, far above the expected run of under two thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin err_count++; tally_and_finish(); end
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        chk("rst data", dat, 16'h0000);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            pulse(4, 0);
            {lck[0], sup[0], vf[0]} = rows[i][11:9];
            pulse(int'(rows[i][15:12]), 0);
            chk("start", 16'(obs[3]), 16'(rows[i][8]));
            {lck[0], sup[0]} = 2'b00;
            if (rows[i][8]) begin
                rs(0, 8'h00);
                pulse(5, 0);
            end
            rs(0, rows[i][7:0]);
        end
        vf = 2'b00;
        pulse(0, 0);
        chk("fail", 16'(obs[3:2]), 16'h0001);
        rs(0, 8'h88);
        pulse(4, 0);
        rs(0, 8'h80);
        // Erase with suspend, busy reads and the other bank idle
        pulse(1, 0);
        HOST.rd(1'b0, 1'b0, rd, st);
        chk("busy", {rd[15:1], st}, 16'h0001);
        HOST.rd(1'b1, 1'b0, rd, st);
        chk("array", rd, 16'h5A3C);
        rs(1, 8'h80);
        pulse(2, 0);
        chk("pause", 16'(obs[1]), 16'h0001);
        rs(0, 8'h00);
        pulse(6, 0);
        rs(0, 8'hC0);
        pulse(3, 0);
        chk("resume", 16'(obs[0]), 16'h0001);
        rs(0, 8'h00);
        // Held read must not follow the finish until enable toggles
        HOST.rd_open(1'b0, 1'b1);
        pulse(5, 0);
        repeat (8) @(negedge clk);
        HOST.rd_take(rd, st);
        chk("held", rd, 16'h0000);
        HOST.rd_close();
        rs(0, 8'h80);
        // Program suspend with a silent engine: ready by the timeout
        pulse(0, 0);
        pulse(2, 0);
        repeat (1260) @(negedge clk);
        rs(0, 8'h84);
        pulse(3, 0);
        pulse(5, 0);
        rs(0, 8'h80);
        // Error then reset in mid-run
        vf[0] = 1'b1;
        pulse(0, 0);
        pulse(5, 0);
        vf[0] = 1'b0;
        rs(0, 8'h90);
        rst_b = 1'b0;
        @(negedge clk);
        chk("rst data", dat, 16'h0000);
        rst_b = 1'b1;
        rs(0, 8'h80);
        tally_and_finish();
    end
endmodule // fbsr_status_tb
